/* pkg/cswrs_params.svh */
// Constants for the clock switch and reset sequencer
// What this block does
// - Trim fast RC from ten-bit calibration value
// - Trim register resets to all ones
// - Factory calibration bytes are read-only
// - Stored low trim bits sit at 6:5
// - Long programming entry forces fast RC clock
// - Select bit clears fast flag, output high
// - Three wake cycles then wake flag set
// - Switch on wake edge, stop fast RC
// - Deselect enables fast RC, count eight cycles
// - Wake flag clears, fast flag after two
// - Switch on fast edge, stop wake RC
// - Fast RC stopped from wake switch until deselect
// - Wake RC on for wake halt entry
// - External clock keeps wake RC running
// - Crystal oscillators run through reset
// - Pin, detector, watchdog, opcode resets accepted
// - Reset pin held low during delay
// - Delay 4096 cycles, 256 for slow sources
// - Two cycles fetch vector at top
`ifndef CSWRS_PARAMS_SVH
`define CSWRS_PARAMS_SVH
`define CSWRS_ADDR_TRIM 4'h0
`define CSWRS_ADDR_SUPPLY 4'h1
`define CSWRS_ADDR_CLKSW 4'h2
`define CSWRS_ADDR_OPTION 4'h3
`define CSWRS_ADDR_CAL0 4'h4
`define CSWRS_ADDR_RSTSTAT 4'h8
`define CSWRS_TRIM_RESET 8'hff
`define CSWRS_TRIM_LO_POS 5
`define CSWRS_CLKSW_SEL_POS 0
`define CSWRS_CLKSW_FAST_POS 1
`define CSWRS_CLKSW_WAKE_POS 2
`define CSWRS_WAKE_WAIT 3
`define CSWRS_FAST_WAIT 8
`define CSWRS_FAST_FLAG_WAIT 2
`define CSWRS_DELAY_LONG 4096
`define CSWRS_DELAY_SHORT 256
`define CSWRS_FETCH_CYCLES 2
`define CSWRS_VECTOR_ADDR 16'hfffe
`endif

/* pkg/cswrs_pkg.sv */
// Types for the clock switch and reset sequencer
package cswrs_pkg;
    typedef enum logic [2:0] {
        CSWRS_OPT_FAST_RC = 3'h0,
        CSWRS_OPT_WAKE_RC = 3'h1,
        CSWRS_OPT_EXT_CLK = 3'h2,
        CSWRS_OPT_XTAL_FAST = 3'h3,
        CSWRS_OPT_XTAL_SLOW = 3'h4
    } cswrs_clk_opt_t;

    typedef enum logic [3:0] {
        CSWRS_RS_IDLE = 4'b0001,
        CSWRS_RS_ACTIVE = 4'b0010,
        CSWRS_RS_DELAY = 4'b0100,
        CSWRS_RS_FETCH = 4'b1000
    } cswrs_rst_state_t;

    typedef enum logic [5:0] {
        CSWRS_CK_FAST = 6'b000001,
        CSWRS_CK_TO_WAKE = 6'b000010,
        CSWRS_CK_WAKE = 6'b000100,
        CSWRS_CK_FAST_CNT = 6'b001000,
        CSWRS_CK_WAKE_CLR = 6'b010000,
        CSWRS_CK_FAST_SET = 6'b100000
    } cswrs_ck_state_t;
endpackage : cswrs_pkg

/* pkg/cswrs_ctl_if.sv */
// Control carrier between the sequencer top and its two leaves
interface cswrs_ctl_if;
    logic selWake;
    logic fastEdge;
    logic wakeEdge;
    logic fastActive;
    logic wakeActive;
    logic fastRun;
    logic wakeRun;
    logic useWake;
    logic [2:0] resetReq;
    logic resetBusy;
    logic slowSource;
    logic pinLow;
    logic fetchPhase;
    logic [15:0] fetchAddr;
    modport top (output selWake, fastEdge, wakeEdge, resetReq, slowSource,
        input fastActive, wakeActive, fastRun, wakeRun, useWake, resetBusy,
        pinLow, fetchPhase, fetchAddr);
    modport sw (input selWake, fastEdge, wakeEdge,
        output fastActive, wakeActive, fastRun, wakeRun, useWake);
    modport rs (input resetReq, slowSource,
        output resetBusy, pinLow, fetchPhase, fetchAddr);
endinterface : cswrs_ctl_if

/* rtl/cswrs_clock_switch.sv */
// Handshake that moves the startup clock between fast RC and wake RC
`include "cswrs_params.svh"
module cswrs_clock_switch (
    input wire logic ref_clk,
    input wire logic srst,
    cswrs_ctl_if.sw ctl
);
    import cswrs_pkg::*;
    cswrs_ck_state_t state, next_state;
    logic [3:0] cnt, next_cnt;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            CSWRS_CK_FAST: begin
                next_cnt = 4'h0;
                if (ctl.selWake) begin
                    next_state = CSWRS_CK_TO_WAKE;
                end
            end
            CSWRS_CK_TO_WAKE: begin
                if (ctl.wakeEdge) begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'(`CSWRS_WAKE_WAIT - 1)) begin
                        next_state = CSWRS_CK_WAKE;
                        next_cnt = 4'h0;
                    end
                end
            end
            CSWRS_CK_WAKE: begin
                if (!ctl.selWake) begin
                    next_state = CSWRS_CK_FAST_CNT;
                end
            end
            CSWRS_CK_FAST_CNT: begin
                if (ctl.fastEdge) begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'(`CSWRS_FAST_WAIT - 1)) begin
                        next_state = CSWRS_CK_WAKE_CLR;
                        next_cnt = 4'h0;
                    end
                end
            end
            CSWRS_CK_WAKE_CLR: begin
                if (ctl.wakeEdge) begin
                    next_state = CSWRS_CK_FAST_SET;
                end
            end
            CSWRS_CK_FAST_SET: begin
                if (ctl.fastEdge) begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == 4'(`CSWRS_FAST_FLAG_WAIT - 1)) begin
                        next_state = CSWRS_CK_FAST;
                        next_cnt = 4'h0;
                    end
                end
            end
            default: begin
                next_state = CSWRS_CK_FAST;
                next_cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= CSWRS_CK_FAST;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign ctl.fastActive = (state == CSWRS_CK_FAST);
    assign ctl.wakeActive = (state == CSWRS_CK_WAKE) || (state == CSWRS_CK_FAST_CNT);
    assign ctl.useWake = (state == CSWRS_CK_WAKE) || (state == CSWRS_CK_FAST_CNT)
        || (state == CSWRS_CK_WAKE_CLR);
    // Fast RC stops once the wake clock carries the core
    assign ctl.fastRun = !((state == CSWRS_CK_WAKE));
    assign ctl.wakeRun = (state != CSWRS_CK_FAST);

    fast_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(ctl.selWake) && state == CSWRS_CK_FAST |=> !ctl.fastActive)
        else $error("fast flag not cleared on select");
    wake_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(ctl.wakeActive) && $past(state) == CSWRS_CK_TO_WAKE
        |-> $past(ctl.wakeEdge))
        else $error("wake flag set without wake edge");
    fast_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == CSWRS_CK_WAKE |-> !ctl.fastRun)
        else $error("fast RC running while wake selected");
endmodule : cswrs_clock_switch

/* rtl/cswrs_reset_seq.sv */
// Reset sequence: active phase, stabilisation delay, vector fetch
`include "cswrs_params.svh"
module cswrs_reset_seq (
    input wire logic ref_clk,
    input wire logic srst,
    cswrs_ctl_if.rs ctl
);
    import cswrs_pkg::*;
    cswrs_rst_state_t state, next_state;
    logic [12:0] cnt, next_cnt;
    logic [12:0] delayEnd;

    assign delayEnd = ctl.slowSource ? 13'(`CSWRS_DELAY_SHORT - 1)
        : 13'(`CSWRS_DELAY_LONG - 1);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            CSWRS_RS_IDLE: begin
                next_cnt = 13'h0;
                if (|ctl.resetReq) begin
                    next_state = CSWRS_RS_ACTIVE;
                end
            end
            CSWRS_RS_ACTIVE: begin
                next_cnt = 13'h0;
                if (!(|ctl.resetReq)) begin
                    next_state = CSWRS_RS_DELAY;
                end
            end
            CSWRS_RS_DELAY: begin
                next_cnt = cnt + 13'h1;
                if (|ctl.resetReq) begin
                    next_state = CSWRS_RS_ACTIVE;
                    next_cnt = 13'h0;
                end else if (cnt == delayEnd) begin
                    next_state = CSWRS_RS_FETCH;
                    next_cnt = 13'h0;
                end
            end
            CSWRS_RS_FETCH: begin
                next_cnt = cnt + 13'h1;
                if (|ctl.resetReq) begin
                    next_state = CSWRS_RS_ACTIVE;
                    next_cnt = 13'h0;
                end else if (cnt == 13'(`CSWRS_FETCH_CYCLES - 1)) begin
                    next_state = CSWRS_RS_IDLE;
                    next_cnt = 13'h0;
                end
            end
            default: begin
                next_state = CSWRS_RS_IDLE;
                next_cnt = 13'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= CSWRS_RS_IDLE;
            cnt <= 13'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign ctl.resetBusy = (state != CSWRS_RS_IDLE);
    assign ctl.pinLow = (state == CSWRS_RS_ACTIVE) || (state == CSWRS_RS_DELAY);
    assign ctl.fetchPhase = (state == CSWRS_RS_FETCH);
    assign ctl.fetchAddr = `CSWRS_VECTOR_ADDR + 16'(cnt[0]);

    // Separate delay count so the length check does not lean on cnt
    logic [12:0] delaySeen, next_delaySeen;

    always_comb begin
        next_delaySeen = 13'h0;
        if (state == CSWRS_RS_DELAY) begin
            next_delaySeen = delaySeen + 13'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            delaySeen <= 13'h0;
        end else begin
            delaySeen <= next_delaySeen;
        end
    end

    pin_low_a: assert property (@(posedge ref_clk) disable iff (srst)
        $fell(ctl.pinLow) |-> ctl.fetchPhase)
        else $error("reset pin released before delay end");
    fetch_len_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(ctl.fetchPhase) |-> ctl.fetchPhase[*2] ##1 (!ctl.fetchPhase))
        else $error("vector fetch not two cycles");
    delay_len_a: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(ctl.fetchPhase) |-> delaySeen == (ctl.slowSource
        ? 13'(`CSWRS_DELAY_SHORT) : 13'(`CSWRS_DELAY_LONG)))
        else $error("stabilisation delay wrong length");
    count_start_a: assert property (@(posedge ref_clk) disable iff (srst)
        state == CSWRS_RS_ACTIVE |-> cnt == 13'h0)
        else $error("delay counted during active phase");
endmodule : cswrs_reset_seq

/* rtl/cswrs_top.sv */
// Clock switch and reset sequencer with Avalon-MM register slave
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`include "cswrs_params.svh"
module cswrs_top (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fastRcClk,
    input wire logic wakeRcClk,
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe,
    input wire logic lowVoltageReset,
    input wire logic watchdogReset,
    input wire logic illegalOpReset,
    input wire logic longProgEntry,
    input wire logic haltWakeEntry,
    input wire cswrs_pkg::cswrs_clk_opt_t startupClockOption,
    input wire logic [7:0] factoryCal [4],
    output logic [9:0] fastRcTrim,
    output logic fastRcEnable,
    output logic wakeRcEnable,
    output logic xtalEnable,
    output logic switchedClk,
    output logic cpuReset,
    output logic vectorFetch,
    output logic [15:0] vectorAddr
);
    import cswrs_pkg::*;

    cswrs_ctl_if ctl ();

    logic [7:0] rc_trim_register, next_rc_trim_register;
    logic [1:0] trimLow, next_trimLow;
    logic lowfreq_clock_select_bit, next_lowfreq_clock_select_bit;
    logic ackPending, next_ackPending;
    logic [31:0] readData, next_readData;
    logic [1:0] fastSync, wakeSync, pinSync, progSync, haltSync;
    logic [2:0] fastHist, wakeHist;
    logic [1:0] lvdSync, wdgSync, illSync;
    logic [1:0] optSel;
    logic [1:0] pinLowHist;

    // Two-stage synchronisers; second stage feeds the edge history
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fastSync <= 2'h0;
            wakeSync <= 2'h0;
            pinSync <= 2'h3;
            progSync <= 2'h0;
            haltSync <= 2'h0;
            lvdSync <= 2'h0;
            wdgSync <= 2'h0;
            illSync <= 2'h0;
            fastHist <= 3'h0;
            wakeHist <= 3'h0;
            pinLowHist <= 2'h0;
        end else begin
            fastSync <= {fastSync[0], fastRcClk};
            wakeSync <= {wakeSync[0], wakeRcClk};
            pinSync <= {pinSync[0], resetPinIn};
            progSync <= {progSync[0], longProgEntry};
            haltSync <= {haltSync[0], haltWakeEntry};
            lvdSync <= {lvdSync[0], lowVoltageReset};
            wdgSync <= {wdgSync[0], watchdogReset};
            illSync <= {illSync[0], illegalOpReset};
            fastHist <= {fastHist[1:0], fastSync[1]};
            wakeHist <= {wakeHist[1:0], wakeSync[1]};
            pinLowHist <= {pinLowHist[0], ctl.pinLow};
        end
    end

    function automatic logic risingEdge(input logic [2:0] hist);
        risingEdge = hist[1] && !hist[2];
    endfunction : risingEdge

    function automatic logic isSlowSource(input cswrs_clk_opt_t opt);
        isSlowSource = (opt == CSWRS_OPT_WAKE_RC) || (opt == CSWRS_OPT_XTAL_SLOW);
    endfunction : isSlowSource

    assign ctl.fastEdge = risingEdge(fastHist);
    assign ctl.wakeEdge = risingEdge(wakeHist);
    assign ctl.selWake = lowfreq_clock_select_bit;
    // Own pin drive is no fresh request; history covers the sync lag after release
    assign ctl.resetReq = {lvdSync[1], wdgSync[1] || illSync[1],
        !pinSync[1] && !ctl.pinLow && !(|pinLowHist)};
    // Long programming entry overrides the option to the fast RC
    assign ctl.slowSource = !progSync[1] && isSlowSource(startupClockOption);

    cswrs_clock_switch u_switch (
        .ref_clk(ref_clk),
        .srst(srst),
        .ctl(ctl.sw)
    );

    cswrs_reset_seq u_reset (
        .ref_clk(ref_clk),
        .srst(srst),
        .ctl(ctl.rs)
    );

    assign optSel = avs_address[1:0];

    always_comb begin
        next_rc_trim_register = rc_trim_register;
        next_trimLow = trimLow;
        next_lowfreq_clock_select_bit = lowfreq_clock_select_bit;
        next_ackPending = 1'b0;
        next_readData = readData;
        if ((avs_read || avs_write) && !ackPending) begin
            next_ackPending = 1'b1;
            next_readData = 32'h0;
            if (avs_write) begin
                case (avs_address)
                    `CSWRS_ADDR_TRIM: next_rc_trim_register = avs_writedata[7:0];
                    `CSWRS_ADDR_SUPPLY: begin
                        next_trimLow = avs_writedata[`CSWRS_TRIM_LO_POS +: 2];
                    end
                    `CSWRS_ADDR_CLKSW: begin
                        next_lowfreq_clock_select_bit = avs_writedata[`CSWRS_CLKSW_SEL_POS];
                    end
                    // Calibration bytes take no write at all
                    default: next_readData = 32'h0;
                endcase
            end else begin
                case (avs_address)
                    `CSWRS_ADDR_TRIM: next_readData = {24'h0, rc_trim_register};
                    `CSWRS_ADDR_SUPPLY: begin
                        next_readData = {25'h0, trimLow, 5'h0};
                    end
                    `CSWRS_ADDR_CLKSW: begin
                        next_readData = {29'h0, ctl.wakeActive, ctl.fastActive,
                            lowfreq_clock_select_bit};
                    end
                    `CSWRS_ADDR_OPTION: next_readData = {29'h0, startupClockOption};
                    `CSWRS_ADDR_RSTSTAT: begin
                        next_readData = {27'h0, ctl.fetchPhase, ctl.pinLow, ctl.resetReq};
                    end
                    default: begin
                        if (avs_address[3:2] == 2'h1) begin
                            next_readData = {24'h0, factoryCal[optSel]};
                        end else begin
                            next_readData = 32'h0;
                        end
                    end
                endcase
            end
        end
        // Reset sequence wipes the trim, so software must reload it
        if (ctl.resetBusy) begin
            next_rc_trim_register = `CSWRS_TRIM_RESET;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rc_trim_register <= `CSWRS_TRIM_RESET;
            trimLow <= 2'h0;
            lowfreq_clock_select_bit <= 1'b0;
            ackPending <= 1'b0;
            readData <= 32'h0;
        end else begin
            rc_trim_register <= next_rc_trim_register;
            trimLow <= next_trimLow;
            lowfreq_clock_select_bit <= next_lowfreq_clock_select_bit;
            ackPending <= next_ackPending;
            readData <= next_readData;
        end
    end

    assign avs_waitrequest = !ackPending;
    assign avs_readdata = readData;
    assign fastRcTrim = {rc_trim_register, trimLow};
    assign fastRcEnable = ctl.fastRun || progSync[1];
    // Wake RC is forced on for external clock and for wake-halt entry
    assign wakeRcEnable = ctl.wakeRun || (startupClockOption == CSWRS_OPT_EXT_CLK)
        || haltSync[1];
    // Crystal never stops in reset: start-up time would be lost
    assign xtalEnable = (startupClockOption == CSWRS_OPT_XTAL_FAST)
        || (startupClockOption == CSWRS_OPT_XTAL_SLOW);
    // Held high between sources so no runt pulse leaks
    assign switchedClk = progSync[1] ? fastHist[1] : (ctl.useWake ? wakeHist[1]
        : (ctl.fastActive ? fastHist[1] : 1'b1));
    assign resetPinOut = 1'b0;
    assign resetPinOe = ctl.pinLow;
    assign cpuReset = ctl.resetBusy && !ctl.fetchPhase;
    assign vectorFetch = ctl.fetchPhase;
    assign vectorAddr = ctl.fetchAddr;

    trim_reset_a: assert property (@(posedge ref_clk) disable iff (srst)
        ctl.resetBusy |=> rc_trim_register == `CSWRS_TRIM_RESET)
        else $error("trim not restored on reset");
    wait_ack_a: assert property (@(posedge ref_clk) disable iff (srst)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");
    prog_fast_a: assert property (@(posedge ref_clk) disable iff (srst)
        progSync[1] |-> fastRcEnable && !ctl.slowSource)
        else $error("fast RC not forced in programming entry");
    ext_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
        startupClockOption == CSWRS_OPT_EXT_CLK |-> wakeRcEnable)
        else $error("wake RC off with external clock");
endmodule : cswrs_top

/* tb/cswrs_osc_model.sv */
// Oscillator and external reset circuit model for the sequencer
module cswrs_osc_model (
    input wire logic fastRcEnable,
    input wire logic wakeRcEnable,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic extPinLow,
    output logic fastRcClk,
    output logic wakeRcClk,
    output logic resetPinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // Odd half periods keep the edges away from the system clock edges
    initial begin
        fastRcClk = 1'h0;
        forever #83 fastRcClk = fastRcEnable ? ~fastRcClk : 1'h0;
    end
    initial begin
        wakeRcClk = 1'h0;
        forever #141 wakeRcClk = wakeRcEnable ? ~wakeRcClk : 1'h0;
    end
    // Open drain with pull-up
    assign resetPinIn = ((resetPinOe && !resetPinOut) || extPinLow) ? 1'h0 : 1'h1;
endmodule : cswrs_osc_model

/* tb/tb_clock_switch_reset_sequencer.sv */
// Register level testbench for the clock switch and reset sequencer
module tb_clock_switch_reset_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import cswrs_pkg::*;
    logic ref_clk, srst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic fastRcClk, wakeRcClk, resetPinIn, resetPinOut, resetPinOe, extPinLow;
    logic lowVoltageReset, watchdogReset, illegalOpReset, longProgEntry, haltWakeEntry;
    cswrs_clk_opt_t startupClockOption;
    logic [7:0] factoryCal [4];
    logic [9:0] fastRcTrim;
    logic fastRcEnable, wakeRcEnable, xtalEnable, switchedClk, cpuReset, vectorFetch;
    logic [15:0] vectorAddr;
    int errors = 0;
    int check_count = 0;
    int wakeEdges = 0;
    int fastEdges = 0;

    cswrs_top dut (
        .ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .fastRcClk, .wakeRcClk, .resetPinIn,
        .resetPinOut, .resetPinOe, .lowVoltageReset, .watchdogReset, .illegalOpReset,
        .longProgEntry, .haltWakeEntry, .startupClockOption, .factoryCal, .fastRcTrim,
        .fastRcEnable, .wakeRcEnable, .xtalEnable, .switchedClk, .cpuReset,
        .vectorFetch, .vectorAddr
    );
    cswrs_osc_model osc (
        .fastRcEnable, .wakeRcEnable, .resetPinOut, .resetPinOe, .extPinLow,
        .fastRcClk, .wakeRcClk, .resetPinIn
    );

    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge wakeRcClk) wakeEdges++;
    always @(posedge fastRcClk) fastEdges++;

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            errors++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_rng
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'h0 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        check_rng("bus wait", 0, 49, n);
    endtask : bus
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'h0, a, 32'h0, d);
        check_val(what, exp, d);
    endtask : rd_chk
    task automatic run_reset(input int src, input cswrs_clk_opt_t opt, input logic prog,
            input int dly);
        int n, m;
        logic [31:0] d;
        @(posedge ref_clk);
        startupClockOption <= opt;
        longProgEntry <= prog;
        bus(1'h1, 4'h0, 32'h5a, d);
        @(posedge ref_clk);
        case (src)
            0: watchdogReset <= 1'h1;
            1: lowVoltageReset <= 1'h1;
            2: illegalOpReset <= 1'h1;
            default: extPinLow <= 1'h1;
        endcase
        repeat (8) @(posedge ref_clk);
        bus(1'h0, 4'h8, 32'h0, d);
        // Own pin drive masks the pin request, so that source shows pin low only
        check_val("request status", src == 1 ? 32'hc : src == 3 ? 32'h8 : 32'ha, d & 32'hf);
        if (opt inside {CSWRS_OPT_XTAL_FAST, CSWRS_OPT_XTAL_SLOW}) begin
            check_val("xtal running", 32'h1, {31'h0, xtalEnable});
        end
        @(posedge ref_clk);
        {watchdogReset, lowVoltageReset, illegalOpReset, extPinLow} <= 4'h0;
        n = 0;
        m = 0;
        @(negedge ref_clk);
        while (cpuReset === 1'h1 && n < 5000) begin
            n++;
            if (resetPinOe === 1'h1) m++;
            @(negedge ref_clk);
        end
        // Pin source is already in its delay when the pin is let go
        check_rng("delay cycles", src == 3 ? dly - 12 : dly, dly + 8, n);
        check_rng("pin low cycles", n, n, m);
        check_val("fetch first", {16'h1, 16'hfffe}, {15'h0, vectorFetch, vectorAddr});
        @(negedge ref_clk);
        check_val("fetch second", {16'h1, 16'hffff}, {15'h0, vectorFetch, vectorAddr});
        @(negedge ref_clk);
        check_val("fetch end", 32'h0, {31'h0, vectorFetch});
        rd_chk("trim after reset", 4'h0, 32'hff);
    endtask : run_reset
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        $display("mismatch watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        int n, e0;
        logic [31:0] d;
        int srcs [5] = '{0, 1, 2, 1, 3};
        int dlys [5] = '{4096, 256, 4096, 256, 4096};
        logic progs [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
        cswrs_clk_opt_t opts [5] = '{CSWRS_OPT_FAST_RC, CSWRS_OPT_WAKE_RC,
            CSWRS_OPT_XTAL_FAST, CSWRS_OPT_XTAL_SLOW, CSWRS_OPT_WAKE_RC};
        srst = 1'h1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {lowVoltageReset, watchdogReset, illegalOpReset, longProgEntry, haltWakeEntry} = '0;
        extPinLow = 1'h1;
        startupClockOption = CSWRS_OPT_FAST_RC;
        factoryCal = '{8'h9c, 8'h40, 8'ha3, 8'h20};
        repeat (16) @(posedge ref_clk);
        srst <= 1'h0;
        repeat (8) @(posedge ref_clk);
        extPinLow <= 1'h0;
        n = 0;
        repeat (10) @(negedge ref_clk);
        while (cpuReset !== 1'h0 && n < 6000) begin
            @(negedge ref_clk);
            n++;
        end
        check_rng("startup delay", 4070, 4100, n);
        rd_chk("trim reset", 4'h0, 32'hff);
        bus(1'h1, 4'h0, 32'h5a, d);
        bus(1'h1, 4'h1, 32'h40, d);
        rd_chk("trim", 4'h0, 32'h5a);
        check_val("trim out", 32'h16a, {22'h0, fastRcTrim});
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, 4'(4 + i), 32'h0, d);
            rd_chk("factory byte", 4'(4 + i), {24'h0, factoryCal[i]});
        end
        bus(1'h1, 4'hf, 32'hffff, d);
        rd_chk("unmapped", 4'hf, 32'h0);
        e0 = wakeEdges;
        bus(1'h1, 4'h2, 32'h1, d);
        repeat (2) @(negedge ref_clk);
        check_val("switched high", 32'h1, {31'h0, switchedClk});
        rd_chk("fast flag clear", 4'h2, 32'h1);
        d = 0;
        n = 0;
        while (d[2] !== 1'h1 && n < 100) begin
            bus(1'h0, 4'h2, 32'h0, d);
            n++;
        end
        check_rng("wake edges", 3, 5, wakeEdges - e0);
        check_val("wake flags", 32'h5, d & 32'h7);
        n = 0;
        while (fastRcEnable !== 1'h0 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check_val("fast stopped", 32'h0, {31'h0, fastRcEnable});
        e0 = fastEdges;
        bus(1'h1, 4'h2, 32'h0, d);
        repeat (2) @(negedge ref_clk);
        check_val("fast enabled", 32'h1, {31'h0, fastRcEnable});
        d = 0;
        n = 0;
        while (d[1] !== 1'h1 && n < 100) begin
            bus(1'h0, 4'h2, 32'h0, d);
            n++;
        end
        check_rng("fast edges", 10, 15, fastEdges - e0);
        check_val("fast flags", 32'h2, d & 32'h7);
        n = 0;
        while (wakeRcEnable !== 1'h0 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check_val("wake stopped", 32'h0, {31'h0, wakeRcEnable});
        @(posedge ref_clk);
        haltWakeEntry <= 1'h1;
        repeat (3) @(negedge ref_clk);
        check_val("wake for halt", 32'h1, {31'h0, wakeRcEnable});
        @(posedge ref_clk);
        haltWakeEntry <= 1'h0;
        startupClockOption <= CSWRS_OPT_EXT_CLK;
        repeat (3) @(negedge ref_clk);
        check_val("wake with ext", 32'h1, {31'h0, wakeRcEnable});
        for (int i = 0; i < 5; i++) begin
            run_reset(srcs[i], opts[i], progs[i], dlys[i]);
        end
        end_sim();
    end
endmodule : tb_clock_switch_reset_sequencer
